// ---- shared/irq_prio_pkg.sv ----
// Package for the interrupt priority and pin enable block.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
`default_nettype none

package irq_prio_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_BANKS = 14;
  localparam int NUM_PINS = 16;
  localparam int NUM_INT = 40;
  localparam int NUM_SRC = 56;
  localparam int ADDR_W = 8;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] PRIO_BANK_BASE = 8'h00;
  localparam logic [7:0] PRIO_BANK_LAST = 8'h34;
  localparam logic [7:0] PIN_REQUEST_ENABLE_OFF = 8'h40;
  localparam logic [7:0] PIN_SENSE_SELECT_HI_OFF = 8'h44;
  localparam logic [7:0] PIN_SENSE_SELECT_LO_OFF = 8'h48;
  localparam logic [7:0] PIN_STATUS_OFF = 8'h4c;
  localparam logic [7:0] PIN_STATUS_MASK_OFF = 8'h50;
  localparam logic [7:0] PRESENT_OFF = 8'h54;

  // ==========================================================================
  // Field layout and reset values
  localparam logic [15:0] PRIO_WRITABLE = 16'h7777;
  localparam logic [15:0] PRIO_RST = 16'h7777;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [15:0] SENSE_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam int FIELD_STRIDE = 4;
  localparam int FIELDS_PER_BANK = 4;
  localparam int PRESENT_VALID_BIT = 16;
  localparam int PRESENT_LVL_LSB = 8;

  // ==========================================================================
  // Pin sense modes, upper bit selects rise and lower bit selects fall
  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_FALL = 2'b01,
    SENSE_RISE = 2'b10,
    SENSE_BOTH = 2'b11
  } sense_type;

  typedef logic [15:0] bank_array_type [NUM_BANKS];

  // Level of one source, read from its 3-bit field
  function automatic logic [2:0] field_of(input bank_array_type banks, input logic [5:0] src);
    logic [15:0] word;
    logic [1:0] slot;
    word = banks[src[5:2]];
    slot = src[1:0];
    return word[slot*FIELD_STRIDE +: 3];
  endfunction

  // Event detection for one pin in a given sense mode
  function automatic logic sense_hit(input logic [1:0] mode, input logic prev, input logic now);
    case (mode)
      SENSE_LOW: return !now;
      SENSE_FALL: return prev && !now;
      SENSE_RISE: return !prev && now;
      default: return prev != now;
    endcase
  endfunction

endpackage

`default_nettype wire

// ---- hdl/irq_priority_and_enable.sv ----
// Interrupt priority and external pin enable block with APB register access.
// Assumes pin and source inputs synchronous to sys_clk, APB master at same clock.
//
// Operation
// - Each priority field is three bits, 000 lowest level and 111 highest.
// - A priority register holds four fields at bits 14:12, 10:8, 6:4 and 2:0.
// - Bits 15, 11, 7 and 3 of every priority register read zero and drop writes.
// - The non-maskable request bypasses every priority field.
// - A pin request reaches the CPU only while its enable bit is one.
// - Enable bits of pins 3 to 0 do not gate the standby wake path.
// - Enable bits are read-write and act from the cycle after the write.
// - Sense codes 00 low level, 01 falling, 10 rising, 11 both edges.
//
// Local design decisions: the APB register port and the address map.
`default_nettype none

module irq_priority_and_enable (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] irq_pin,
  input wire logic [39:0] int_req,
  input wire logic nmi_pin,
  output logic nmi_req,
  output logic cpu_req,
  output logic [5:0] cpu_src,
  output logic [2:0] cpu_lvl,
  output logic [3:0] wake_req,
  output logic irq
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Register state
  irq_prio_pkg::bank_array_type prio_r, prio_nxt;
  logic [15:0] enable_r, enable_nxt;
  logic [15:0] sense_hi_r, sense_hi_nxt;
  logic [15:0] sense_lo_r, sense_lo_nxt;
  logic [15:0] status_r, status_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic [15:0] pin_prev_r, pin_prev_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] sense_all;
  logic [15:0] hit;
  logic wr_en;
  logic setup;
  logic mapped;
  logic [3:0] bank_sel;
  logic prio_wr;

  // Bus decode
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign bank_sel = paddr[5:2];
  assign prio_wr = wr_en && paddr <= irq_prio_pkg::PRIO_BANK_LAST && paddr[1:0] == 2'b00;
  assign sense_all = {sense_hi_r, sense_lo_r};
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r && psel && penable;

  // Pin event detection per sense mode
  always_comb begin
    for (int n = 0; n < irq_prio_pkg::NUM_PINS; n++) begin
      hit[n] = irq_prio_pkg::sense_hit(sense_all[2*n +: 2], pin_prev_r[n], irq_pin[n]);
    end
  end

  // Next values of the register file
  always_comb begin
    prio_nxt = prio_r;
    enable_nxt = enable_r;
    sense_hi_nxt = sense_hi_r;
    sense_lo_nxt = sense_lo_r;
    mask_nxt = mask_r;
    status_nxt = status_r;
    pin_prev_nxt = irq_pin;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (prio_wr) begin
      prio_nxt[bank_sel] = pwdata[15:0] & irq_prio_pkg::PRIO_WRITABLE;
    end
    if (wr_en) begin
      unique case (paddr)
        irq_prio_pkg::PIN_REQUEST_ENABLE_OFF: enable_nxt = pwdata[15:0];
        irq_prio_pkg::PIN_SENSE_SELECT_HI_OFF: sense_hi_nxt = pwdata[15:0];
        irq_prio_pkg::PIN_SENSE_SELECT_LO_OFF: sense_lo_nxt = pwdata[15:0];
        irq_prio_pkg::PIN_STATUS_MASK_OFF: mask_nxt = pwdata[15:0];
        irq_prio_pkg::PIN_STATUS_OFF: status_nxt = status_r & ~pwdata[15:0];
        default: ;
      endcase
    end
    // New events win over a clear in the same cycle
    status_nxt = status_nxt | hit;
    if (setup) begin
      mapped = 1'b1;
      prdata_nxt = 32'h0000_0000;
      if (paddr <= irq_prio_pkg::PRIO_BANK_LAST && paddr[1:0] == 2'b00) begin
        prdata_nxt = {16'h0000, prio_r[bank_sel] & irq_prio_pkg::PRIO_WRITABLE};
      end else begin
        unique case (paddr)
          irq_prio_pkg::PIN_REQUEST_ENABLE_OFF: prdata_nxt = {16'h0000, enable_r};
          irq_prio_pkg::PIN_SENSE_SELECT_HI_OFF: prdata_nxt = {16'h0000, sense_hi_r};
          irq_prio_pkg::PIN_SENSE_SELECT_LO_OFF: prdata_nxt = {16'h0000, sense_lo_r};
          irq_prio_pkg::PIN_STATUS_OFF: prdata_nxt = {16'h0000, status_r};
          irq_prio_pkg::PIN_STATUS_MASK_OFF: prdata_nxt = {16'h0000, mask_r};
          irq_prio_pkg::PRESENT_OFF: prdata_nxt = {15'h0000, cpu_req, 5'h00, cpu_lvl, 2'h0, cpu_src};
          default: mapped = 1'b0;
        endcase
      end
      pslverr_nxt = !mapped;
    end else begin
      mapped = 1'b1;
    end
  end

  // Register file flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int b = 0; b < irq_prio_pkg::NUM_BANKS; b++) begin
        prio_r[b] <= irq_prio_pkg::PRIO_RST;
      end
      enable_r <= irq_prio_pkg::ENABLE_RST;
      sense_hi_r <= irq_prio_pkg::SENSE_RST;
      sense_lo_r <= irq_prio_pkg::SENSE_RST;
      status_r <= irq_prio_pkg::STATUS_RST;
      mask_r <= irq_prio_pkg::MASK_RST;
      pin_prev_r <= 16'hffff;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      prio_r <= prio_nxt;
      enable_r <= enable_nxt;
      sense_hi_r <= sense_hi_nxt;
      sense_lo_r <= sense_lo_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      pin_prev_r <= pin_prev_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ==========================================================================
  // Arbitration
  logic [55:0] pend;
  logic found;
  logic [5:0] best_idx;
  logic [2:0] best_lvl;
  logic [2:0] lvl_i;
  logic cpu_req_r, cpu_req_nxt;
  logic [5:0] cpu_src_r, cpu_src_nxt;
  logic [2:0] cpu_lvl_r, cpu_lvl_nxt;
  logic nmi_req_r, nmi_req_nxt;
  logic [3:0] wake_r, wake_nxt;
  logic irq_r, irq_nxt;

  // Pin requests gated by enable, internal sources as they come
  assign pend = {int_req, status_r & enable_r};

  // Pick the highest level, strict compare keeps the lower source on a tie
  always_comb begin
    found = 1'b0;
    best_idx = 6'h00;
    best_lvl = 3'h0;
    lvl_i = 3'h0;
    for (int s = 0; s < irq_prio_pkg::NUM_SRC; s++) begin
      lvl_i = irq_prio_pkg::field_of(prio_r, 6'(s));
      if (pend[s] && (!found || lvl_i > best_lvl)) begin
        found = 1'b1;
        best_idx = 6'(s);
        best_lvl = lvl_i;
      end
    end
  end

  // Next values of the CPU side outputs
  always_comb begin
    cpu_req_nxt = found;
    cpu_src_nxt = found ? best_idx : cpu_src_r;
    cpu_lvl_nxt = found ? best_lvl : cpu_lvl_r;
    nmi_req_nxt = nmi_pin;
    wake_nxt = hit[3:0];
    irq_nxt = |(status_r & mask_r);
  end

  // CPU side flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_req_r <= 1'b0;
      cpu_src_r <= 6'h00;
      cpu_lvl_r <= 3'h0;
      nmi_req_r <= 1'b0;
      wake_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      cpu_req_r <= cpu_req_nxt;
      cpu_src_r <= cpu_src_nxt;
      cpu_lvl_r <= cpu_lvl_nxt;
      nmi_req_r <= nmi_req_nxt;
      wake_r <= wake_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign cpu_req = cpu_req_r;
  assign cpu_src = cpu_src_r;
  assign cpu_lvl = cpu_lvl_r;
  assign nmi_req = nmi_req_r;
  assign wake_req = wake_r;
  assign irq = irq_r;

  // ==========================================================================
  // Checks
  logic higher_exists;

  // Any pending source with a strictly higher level than the winner
  always_comb begin
    higher_exists = 1'b0;
    for (int s = 0; s < irq_prio_pkg::NUM_SRC; s++) begin
      if (pend[s] && irq_prio_pkg::field_of(prio_r, 6'(s)) > best_lvl) begin
        higher_exists = 1'b1;
      end
    end
  end

  // Winner level matches the field of the presented source
  winner_level_a: assert property (found && !prio_wr |=>
    cpu_req && cpu_lvl == irq_prio_pkg::field_of(prio_r, cpu_src))
    else $error("presented level differs from the source field");

  // A write to the first bank lands with reserved bits dropped
  prio_write_a: assert property (prio_wr && paddr == irq_prio_pkg::PRIO_BANK_BASE |=>
    prio_r[0] == ($past(pwdata[15:0]) & irq_prio_pkg::PRIO_WRITABLE))
    else $error("priority bank write not stored");

  // Reserved priority bits always read back as zero
  reserved_zero_a: assert property (psel && penable && !pwrite &&
    paddr <= irq_prio_pkg::PRIO_BANK_LAST |-> (prdata & 32'hffff_8888) == 32'h0)
    else $error("reserved priority bits read nonzero");

  // Non-maskable request follows its pin one cycle later
  nmi_bypass_a: assert property ($rose(nmi_pin) |=> nmi_req ##1 ($past(nmi_pin) == nmi_req))
    else $error("non-maskable request not passed through");

  // Priority writes never disturb the non-maskable path
  nmi_no_prio_a: assert property (prio_wr |=> nmi_req == $past(nmi_pin))
    else $error("non-maskable request disturbed by a priority write");

  // Only enabled pins can win
  pin_gated_a: assert property (found && best_idx < 6'd16 |-> enable_r[best_idx[3:0]])
    else $error("disabled pin reached the CPU");

  // Nothing pending leaves the request line low
  cpu_idle_a: assert property (!found |=> !cpu_req)
    else $error("request presented with nothing pending");

  // Wake events pass whatever the enable bit holds
  wake_ungated_a: assert property (hit[0] && !enable_r[0] |=> wake_req[0])
    else $error("wake path gated by enable bit");

  // Enable writes land whole
  enable_write_a: assert property (wr_en && paddr == irq_prio_pkg::PIN_REQUEST_ENABLE_OFF |=>
    enable_r == $past(pwdata[15:0]))
    else $error("enable register write not stored");

  // Falling edge on pin 4 in falling mode sets its status bit
  fall_sense_a: assert property (sense_lo_r[9:8] == irq_prio_pkg::SENSE_FALL &&
    pin_prev_r[4] && !irq_pin[4] |=> status_r[4])
    else $error("falling edge on pin 4 not flagged");

  // A pin event wins over a clear written in the same cycle
  set_wins_a: assert property (wr_en && paddr == irq_prio_pkg::PIN_STATUS_OFF |=>
    (status_r & $past(hit)) == $past(hit))
    else $error("status clear swallowed a new event");

  // No pending source outranks the winner
  highest_wins_a: assert property (found |-> !higher_exists)
    else $error("a higher level request was passed over");

  // On equal levels the lower source number wins
  tie_order_a: assert property (found && pend[0] &&
    irq_prio_pkg::field_of(prio_r, 6'h00) == best_lvl |-> best_idx == 6'h00)
    else $error("tie not broken towards the lower source");

  // ==========================================================================
  // Coverage of the main scenarios
  tie_cover_c: cover property (pend[0] && pend[1] && found && best_idx == 6'd0);
  both_edge_c: cover property (sense_lo_r[9:8] == irq_prio_pkg::SENSE_BOTH && hit[4]);
  internal_win_c: cover property (found && best_idx >= 6'd16);
  slverr_c: cover property (pslverr);
  present_read_c: cover property (setup && paddr == irq_prio_pkg::PRESENT_OFF && cpu_req);

endmodule

`default_nettype wire

// ---- bench/cpu_model.sv ----
// CPU side model that takes each new winning request from the block.
// Assumes cpu_req, cpu_src and cpu_lvl are registered outputs on sys_clk.
`default_nettype none

module cpu_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cpu_req,
  input wire logic [5:0] cpu_src,
  input wire logic [2:0] cpu_lvl,
  output logic took
);
  timeunit 1ns;
  timeprecision 1ns;

  logic seen_r;
  logic [8:0] last_r;

  // ==========================================================================
  // Take
  // A take is a fresh request, or a new source or level while one stands
  assign took = cpu_req && (!seen_r || last_r != {cpu_src, cpu_lvl});

  // Remember what was offered last cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seen_r <= 1'b0;
      last_r <= 9'h000;
    end else begin
      seen_r <= cpu_req;
      last_r <= {cpu_src, cpu_lvl};
    end
  end
endmodule

`default_nettype wire

// ---- bench/irq_priority_and_enable_test.sv ----
// Self-checking bench for the priority and pin enable block.
// Assumes the package offsets and a zero-wait APB slave on sys_clk.
`default_nettype none

module irq_priority_and_enable_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] EN = irq_prio_pkg::PIN_REQUEST_ENABLE_OFF;
  localparam logic [7:0] SLO = irq_prio_pkg::PIN_SENSE_SELECT_LO_OFF;
  localparam logic [7:0] SHI = irq_prio_pkg::PIN_SENSE_SELECT_HI_OFF;
  localparam logic [7:0] ST = irq_prio_pkg::PIN_STATUS_OFF;
  localparam logic [7:0] MK = irq_prio_pkg::PIN_STATUS_MASK_OFF;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] irq_pin = 16'hffff;
  logic [39:0] int_req = 40'h0;
  logic nmi_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, nmi_req, cpu_req, irq, took;
  logic [5:0] cpu_src;
  logic [2:0] cpu_lvl;
  logic [3:0] wake_req;
  logic [8:0] q_exp [$];
  logic [31:0] q, r;
  logic e;
  int err_total = 0;
  int checks_done = 0;

  irq_priority_and_enable u_irq_priority_and_enable (.sys_clk(sys_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_pin(irq_pin),
    .int_req(int_req), .nmi_pin(nmi_pin), .nmi_req(nmi_req), .cpu_req(cpu_req),
    .cpu_src(cpu_src), .cpu_lvl(cpu_lvl), .wake_req(wake_req), .irq(irq));
  cpu_model u_cpu_model (.sys_clk(sys_clk), .nrst(nrst), .cpu_req(cpu_req),
    .cpu_src(cpu_src), .cpu_lvl(cpu_lvl), .took(took));

  always #5 sys_clk = ~sys_clk;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk({e, q & m}, {1'b0, x});
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // Monitor: each take by the CPU consumes the oldest expectation
  always @(posedge sys_clk) begin
    if (took === 1'b1) chk({cpu_src, cpu_lvl}, q_exp.size() ? q_exp.pop_front() : 'x);
  end

  // Watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(50));
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 14; i++) rd(8'(i * 4), '1, 32'h7777);
    rd(EN, '1, 32'h0);
    r = $urandom;
    wr(8'h08, r[15:0]);
    rd(8'h08, '1, {16'h0, r[15:0] & irq_prio_pkg::PRIO_WRITABLE});
    wr(8'h04, 16'hffff);
    rd(8'h04, '1, 32'h7777);
    apb(1'b0, 8'h3c, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    wr(EN, 16'ha5c3);
    rd(EN, '1, 32'ha5c3);
    wr(EN, 16'h0);
    wr(8'h00, 16'h0052);
    irq_pin[1:0] <= 2'b00;
    repeat (3) @(posedge sys_clk);
    chk(wake_req[1:0], 2'b11);
    chk(cpu_req, 1'b0);
    q_exp.push_back({6'd1, 3'd5});
    wr(EN, 16'h0003);
    q_exp.push_back({6'd0, 3'd5});
    wr(8'h00, 16'h0055);
    q_exp.push_back({6'd0, 3'd0});
    wr(8'h00, 16'h0000);
    q_exp.push_back({6'd1, 3'd0});
    wr(EN, 16'h0002);
    wr(EN, 16'h0000);
    repeat (3) @(posedge sys_clk);
    chk(cpu_req, 1'b0);
    wr(MK, 16'h0001);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b1);
    wr(MK, 16'h0000);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    irq_pin[1:0] <= 2'b11;
    wr(ST, 16'hffff);
    rd(ST, '1, 32'h0);
    wr(MK, 16'h0001);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    nmi_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(nmi_req, 1'b1);
    nmi_pin <= 1'b0;
    // Every sense mode on pin 4: falling phase, then rising phase
    for (int m = 0; m < 4; m++) begin
      wr(SLO, 16'(m << 8));
      wr(ST, 16'h0010);
      irq_pin[4] <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd(ST, 32'h10, (m != 2) ? 32'h10 : 32'h0);
      wr(ST, 16'h0010);
      irq_pin[4] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(ST, 32'h10, (m == 0 || m > 1) ? 32'h10 : 32'h0);
    end
    // Rising sense on pin 12 through the upper sense register
    wr(SHI, 16'h0200);
    rd(SHI, '1, 32'h0200);
    irq_pin[12] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(ST, 32'h1000, 32'h0);
    irq_pin[12] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(ST, 32'h1000, 32'h1000);
    // Internal source wins and shows in the present register
    wr(8'h10, 16'h0006);
    q_exp.push_back({6'd16, 3'd6});
    int_req[0] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    r = (32'h1 << irq_prio_pkg::PRESENT_VALID_BIT) | (32'h6 << irq_prio_pkg::PRESENT_LVL_LSB);
    rd(irq_prio_pkg::PRESENT_OFF, '1, r | 32'h10);
    int_req[0] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(q_exp.size(), 0);
    end_of_test();
  end
endmodule

`default_nettype wire
